// ===== design/acr_ctrl_regs.sv
/*
  Accelerometer core control registers: rate/mode and interface/reset control,
  with decoded rate, mode and interface settings for the rest of the sensor.
  Assumes a serial front end presenting one-cycle byte read/write strobes with an address,
  and that it applies the auto-increment and protocol settings driven from here.
*/
// Contract
// RQ1: rate code 0000 puts the sensor in power-down.
// RQ2: code 0001 gives 12.5 Hz high-performance, 1.6 Hz low-power.
// RQ3: codes 0010 to 0110 give 12.5 to 200 Hz in both modes.
// RQ4: codes 0111 to 1001 give 400/800/1600 Hz, low-power capped at 200 Hz.
// RQ5: mode 00 low-power, 01 high-performance 14-bit.
// RQ6: mode 10 single conversion on demand, one sample per request.
// RQ7: variant 00 is 12-bit, variants 01 to 11 are 14-bit.
// RQ8: host always writes zero to bit 5 of interface control.
// RQ9: trim bit starts nonvolatile copy, clears itself when done, resets 0.
// RQ10: control-reset bit restores all control registers to defaults, then clears; code keeps the trim bit set until its copy is done.
// RQ11: pull-up off bit, default 0, disconnects chip-select pull-up at 1.
// RQ12: hold bit 0 updates outputs freely; 1 holds until both bytes read.
// RQ13: auto-increment, default 1, advances address per byte of multi-byte access.
// RQ14: I2C disable, default 0; at 1 only SPI responds.
// RQ15: SPI wire select, default 0 four-wire, 1 three-wire.
// RQ16: host never writes mode 11, which is undefined.
module acr_ctrl_regs
  import acr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // register access from serial front end
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // single conversion request and sample pulse
  input wire logic convert_req_i,
  output logic sample_req_o,
  // decoded settings and trim-copy status
  output logic power_down_o,
  output acr_pkg::acr_mode_t mode_o,
  output logic [2:0] rate_idx_o,
  output logic res_14bit_o,
  output logic select_pullup_off_o,
  output logic hold_outputs_until_read_o,
  output logic addr_auto_inc_o,
  output logic i2c_enable_o,
  output logic spi_three_wire_o,
  output logic nvm_load_o,
  output logic trim_busy_o
);
  import acr_pkg::*;

  logic [7:0] rate_and_mode_control;
  logic [7:0] interface_and_reset_control;
  logic [7:0] next_rmc;
  logic [7:0] next_irc;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic sample_q;
  logic next_sample;
  logic [3:0] sample_rate_code;
  logic [1:0] low_power_variant;
  acr_mode_t mode;
  acr_trim_if trim ();

  acr_trim_seq u_trim (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .trim(trim),
    .nvm_load_o(nvm_load_o)
  );

  assign sample_rate_code = rate_and_mode_control[ACR_RATE_HI:ACR_RATE_LO];
  assign low_power_variant = rate_and_mode_control[ACR_LPV_HI:ACR_LPV_LO];
  assign mode = acr_mode_t'(rate_and_mode_control[ACR_MODE_HI:ACR_MODE_LO]);

  // rate index: 0=12.5 1=25 2=50 3=100 4=200 5=400 6=800, 7=1600 in high-performance, 1.6 Hz otherwise
  function automatic logic [2:0] rate_index(input logic [3:0] code, input logic lp);
    logic [2:0] idx;
    idx = ACR_IDX_12P5;
    if (code == ACR_RATE_LOWEST) begin
      idx = lp ? ACR_IDX_1P6 : ACR_IDX_12P5;
    end else if (code > ACR_RATE_LOWEST && code <= ACR_RATE_LP_MAX) begin
      idx = 3'(code - 4'h2);
    end else if (code > ACR_RATE_LP_MAX && code <= ACR_RATE_TOP) begin
      idx = lp ? (ACR_IDX_200 - 3'h1) : 3'(code - 4'h2);
    end
    return idx;
  endfunction

  always_comb begin
    next_rmc = rate_and_mode_control;
    next_irc = interface_and_reset_control;
    next_rdata = rdata;
    next_sample = 1'b0;
    if (reg_wr_i && reg_addr_i == ACR_ADDR_RATE_MODE) begin
      next_rmc = reg_wdata_i;
    end
    // RQ9 trim bit self-clear, host set wins
    if (trim.done) begin
      next_irc[ACR_BIT_TRIM] = 1'b0;
    end
    if (reg_wr_i && reg_addr_i == ACR_ADDR_IF_RESET) begin
      next_irc = reg_wdata_i;
    end
    // RQ10 control reset restores
    if (interface_and_reset_control[ACR_BIT_SOFTRST]) begin
      next_rmc = ACR_RATE_MODE_RST;
      next_irc = ACR_IF_RESET_RST;
      next_irc[ACR_BIT_TRIM] = interface_and_reset_control[ACR_BIT_TRIM] & ~trim.done;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ACR_ADDR_RATE_MODE: next_rdata = rate_and_mode_control;
        ACR_ADDR_IF_RESET: next_rdata = interface_and_reset_control;
        default: next_rdata = 8'h00;
      endcase
    end
    // RQ6 one sample per request
    if (mode == ACR_MODE_SINGLE && convert_req_i && !power_down_o) begin
      next_sample = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rate_and_mode_control <= ACR_RATE_MODE_RST;
      interface_and_reset_control <= ACR_IF_RESET_RST;
      rdata <= 8'h00;
      sample_q <= 1'b0;
    end else if (ce_i) begin
      rate_and_mode_control <= next_rmc;
      interface_and_reset_control <= next_irc;
      rdata <= next_rdata;
      sample_q <= next_sample;
    end
  end

  // RQ9 start copy
  assign trim.start = interface_and_reset_control[ACR_BIT_TRIM] && !trim.busy;
  assign trim_busy_o = trim.busy;
  assign reg_rdata_o = rdata;
  assign reg_hit_o = (reg_addr_i == ACR_ADDR_RATE_MODE) || (reg_addr_i == ACR_ADDR_IF_RESET);
  assign sample_req_o = sample_q;
  // RQ1 power-down code
  assign power_down_o = (sample_rate_code == ACR_RATE_OFF);
  // RQ5 mode decode
  assign mode_o = mode;
  // RQ2 RQ3 RQ4 rate selection
  assign rate_idx_o = rate_index(sample_rate_code, mode != ACR_MODE_HP);
  // RQ7 resolution by variant
  assign res_14bit_o = (mode == ACR_MODE_HP) || (low_power_variant != ACR_LPV_1);
  // RQ11 pull-up switch
  assign select_pullup_off_o = interface_and_reset_control[ACR_BIT_PULLUP];
  // RQ12 output hold
  assign hold_outputs_until_read_o = interface_and_reset_control[ACR_BIT_HOLD];
  // RQ13 address advance
  assign addr_auto_inc_o = interface_and_reset_control[ACR_BIT_AUTOINC];
  // RQ14 protocol enable
  assign i2c_enable_o = !interface_and_reset_control[ACR_BIT_I2COFF];
  // RQ15 wire count
  assign spi_three_wire_o = interface_and_reset_control[ACR_BIT_SPIWIRE];

  write_rate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ1
    ce_i && reg_wr_i && reg_addr_i == ACR_ADDR_RATE_MODE && !interface_and_reset_control[ACR_BIT_SOFTRST]
    |=> power_down_o == ($past(reg_wdata_i[ACR_RATE_HI:ACR_RATE_LO]) == ACR_RATE_OFF))
    else $error("power-down does not follow rate write");
  lp_cap_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ4
    mode != ACR_MODE_HP && sample_rate_code > ACR_RATE_LP_MAX && sample_rate_code <= ACR_RATE_TOP
    |-> rate_idx_o == 3'h4)
    else $error("low-power rate not capped");
  slow_rate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ2
    sample_rate_code == ACR_RATE_LOWEST |-> rate_idx_o == ((mode == ACR_MODE_HP) ? ACR_IDX_12P5 : ACR_IDX_1P6))
    else $error("lowest rate code decoded wrongly");
  mid_rate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ3
    sample_rate_code == 4'h6 |-> rate_idx_o == 3'h4)
    else $error("200 Hz code decoded wrongly");
  res_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ7
    mode == ACR_MODE_LP && low_power_variant == ACR_LPV_1 |-> !res_14bit_o)
    else $error("variant one not 12-bit");
  single_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ6
    ce_i && mode != ACR_MODE_SINGLE |=> !sample_req_o)
    else $error("sample outside single mode");
  trim_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ9
    ce_i && trim.done && !(reg_wr_i && reg_addr_i == ACR_ADDR_IF_RESET)
    |=> !interface_and_reset_control[ACR_BIT_TRIM])
    else $error("trim bit not cleared after copy");
  softrst_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ10
    ce_i && interface_and_reset_control[ACR_BIT_SOFTRST]
    |=> rate_and_mode_control == ACR_RATE_MODE_RST && addr_auto_inc_o && !i2c_enable_o == 1'b0)
    else $error("control reset did not restore defaults");
  iface_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RQ14
    ce_i && reg_wr_i && reg_addr_i == ACR_ADDR_IF_RESET && !interface_and_reset_control[ACR_BIT_SOFTRST]
    |=> i2c_enable_o != $past(reg_wdata_i[ACR_BIT_I2COFF]) && spi_three_wire_o == $past(reg_wdata_i[ACR_BIT_SPIWIRE]))
    else $error("interface bits do not follow write");

  cov_trim_c: cover property (@(posedge clk_sys_i) trim.done);
  cov_softrst_c: cover property (@(posedge clk_sys_i) interface_and_reset_control[ACR_BIT_SOFTRST]);
  cov_single_c: cover property (@(posedge clk_sys_i) sample_req_o);
endmodule

// ===== design/acr_pkg.sv
/*
  Constants for the accelerometer core control register pair: addresses, field positions,
  reset values, mode and variant codes, trim-copy timing.
  Assumes a serial front end that hands over byte-wide register reads and writes.
*/
package acr_pkg;
  localparam logic [7:0] ACR_ADDR_RATE_MODE = 8'h20;
  localparam logic [7:0] ACR_ADDR_IF_RESET = 8'h21;
  localparam logic [7:0] ACR_RATE_MODE_RST = 8'h00;
  localparam logic [7:0] ACR_IF_RESET_RST = 8'h04;
  localparam int ACR_RATE_HI = 7;
  localparam int ACR_RATE_LO = 4;
  localparam int ACR_MODE_HI = 3;
  localparam int ACR_MODE_LO = 2;
  localparam int ACR_LPV_HI = 1;
  localparam int ACR_LPV_LO = 0;
  localparam int ACR_BIT_TRIM = 7;
  localparam int ACR_BIT_SOFTRST = 6;
  localparam int ACR_BIT_FIXED0 = 5;
  localparam int ACR_BIT_PULLUP = 4;
  localparam int ACR_BIT_HOLD = 3;
  localparam int ACR_BIT_AUTOINC = 2;
  localparam int ACR_BIT_I2COFF = 1;
  localparam int ACR_BIT_SPIWIRE = 0;
  localparam logic [3:0] ACR_RATE_OFF = 4'h0;
  localparam logic [3:0] ACR_RATE_LOWEST = 4'h1;
  localparam logic [3:0] ACR_RATE_LP_MAX = 4'h6;
  localparam logic [3:0] ACR_RATE_TOP = 4'h9;
  localparam logic [2:0] ACR_IDX_200 = 3'h5;
  localparam logic [2:0] ACR_IDX_12P5 = 3'h0;
  localparam logic [2:0] ACR_IDX_1P6 = 3'h7;
  typedef enum logic [1:0] {
    ACR_MODE_LP = 2'b00,
    ACR_MODE_HP = 2'b01,
    ACR_MODE_SINGLE = 2'b10,
    ACR_MODE_UNDEF = 2'b11
  } acr_mode_t;
  localparam logic [1:0] ACR_LPV_1 = 2'h0;
  localparam int ACR_TRIM_NS = 64;
  localparam int ACR_CLK_NS = 8;
  localparam int ACR_TRIM_CYC = (ACR_TRIM_NS + ACR_CLK_NS - 1) / ACR_CLK_NS;
  localparam logic [3:0] ACR_TRIM_CNT = 4'(ACR_TRIM_CYC);
endpackage

// ===== design/acr_trim_if.sv
/*
  Carrier between the register bank and its trim-copy sequencer.
  Assumes one clock domain shared by both ends.
*/
interface acr_trim_if;
  logic start;
  logic busy;
  logic done;
  modport bank (output start, input busy, input done);
  modport seq (input start, output busy, output done);
endinterface

// ===== design/acr_trim_seq.sv
/*
  Trim-copy sequencer: on start, runs a fixed-length copy from nonvolatile storage
  and pulses done at the end.
  Assumes the storage answers within the fixed copy time.
*/
module acr_trim_seq
  import acr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // bank side
  acr_trim_if.seq trim,
  // storage side
  output logic nvm_load_o
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic run;
  logic next_run;

  always_comb begin
    next_cnt = cnt;
    next_run = run;
    if (!run && trim.start) begin
      next_run = 1'b1;
      next_cnt = ACR_TRIM_CNT;
    end else if (run) begin
      next_cnt = cnt - 4'h1;
      if (cnt == 4'h1) begin
        next_run = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      run <= 1'b0;
    end else if (ce_i) begin
      cnt <= next_cnt;
      run <= next_run;
    end
  end

  assign trim.busy = run;
  assign trim.done = run && (cnt == 4'h1) && ce_i;
  assign nvm_load_o = run;
endmodule

// ===== tb/acr_host_model.sv
/*
  host-side model: byte writes and reads into the control register pair.
  assumes strobes taken on the next rising edge, read data one cycle after the strobe.
*/
module acr_host_model
  import acr_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // register strobes
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ACR_ADDR_IF_RESET) v[ACR_BIT_FIXED0] = 1'b0;
    if (a == ACR_ADDR_RATE_MODE && v[3:2] == 2'b11) v[3:2] = 2'b10;
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= v;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = reg_rdata_i;
  endtask
endmodule

// ===== tb/test_accel_core_control_regs.sv
/*
  self-checking bench for the control register pair, random and corner stimulus.
  assumes the host model drives all register strobes.
*/
module test_accel_core_control_regs
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr, wdata, rdata, v, d;
  logic wr, rd, hit, conv, sample, pd, res14, pu, hold, ainc, i2c, spi3, nvm, busy;
  acr_mode_t mode;
  logic [2:0] ridx;
  int num_errors = 0;
  int tests_run = 0;
  int n, cnt;
  always #4 clk_sys_i = ~clk_sys_i;
  acr_host_model host (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));
  acr_ctrl_regs dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_hit_o(hit),
    .convert_req_i(conv), .sample_req_o(sample), .power_down_o(pd), .mode_o(mode),
    .rate_idx_o(ridx), .res_14bit_o(res14), .select_pullup_off_o(pu),
    .hold_outputs_until_read_o(hold), .addr_auto_inc_o(ainc), .i2c_enable_o(i2c),
    .spi_three_wire_o(spi3), .nvm_load_o(nvm), .trim_busy_o(busy));
  function automatic logic [2:0] exp_idx(input logic [3:0] c, input logic [1:0] m);
    if (c > 4'h9) return 3'h0;
    if (c == 4'h1) return (m == 2'b01) ? 3'h0 : 3'h7;
    if (m != 2'b01 && c > 4'h6) return 3'h4;
    return 3'(c - 4'h2);
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    conv = 1'b0;
    void'($urandom(32'h5bb0));
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    host.rd(ACR_ADDR_RATE_MODE, d);
    chk("rate_mode_rst", d, ACR_RATE_MODE_RST);
    host.rd(ACR_ADDR_IF_RESET, d);
    chk("if_rst", d, ACR_IF_RESET_RST);
    chk("rst_bits", {pd, ainc, i2c, pu, hold, spi3, busy, nvm}, 8'hE0);
    host.wr(8'h22, 8'hFF);
    host.rd(8'h22, d);
    chk("unmapped", d, 8'h00);
    chk("hit_off", 8'(hit), 8'h00);
    host.rd(8'hDF, d);
    chk("unmapped_df", d, 8'h00);
    chk("hit_on", 8'(hit), 8'h01);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      for (int m = 0; m < 3; m++) begin
        v = {4'(c), 2'(m), 2'($urandom)};
        host.wr(ACR_ADDR_RATE_MODE, v);
        host.rd(ACR_ADDR_RATE_MODE, d);
        chk("rate_mode", d, v);
        chk("power_down", 8'(pd), 8'(c == 0));
        chk("mode", 8'(mode), 8'(m));
        chk("res14", 8'(res14), 8'(m == 1 || v[1:0] != 2'b00));
        if (c != 0) chk("rate_idx", 8'(ridx), 8'(exp_idx(4'(c), 2'(m))));
      end
    end
    $display("test rate mode done");
    repeat (8) begin
      v = 8'($urandom) & 8'h1F;
      host.wr(ACR_ADDR_IF_RESET, v);
      host.rd(ACR_ADDR_IF_RESET, d);
      chk("if_reg", d, v);
      chk("if_bits", {3'h0, pu, hold, ainc, ~i2c, spi3}, v);
    end
    $display("test interface done");
    host.wr(ACR_ADDR_RATE_MODE, 8'h55);
    host.wr(ACR_ADDR_IF_RESET, 8'h48);
    host.rd(ACR_ADDR_RATE_MODE, d);
    chk("soft_rst_rm", d, ACR_RATE_MODE_RST);
    host.rd(ACR_ADDR_IF_RESET, d);
    chk("soft_rst_if", d, ACR_IF_RESET_RST);
    $display("test soft reset done");
    host.wr(ACR_ADDR_IF_RESET, 8'h80);
    for (n = 0; n < 20 && nvm !== 1'b1; n++) @(posedge clk_sys_i) #1;
    chk("trim_start", 8'(n < 20), 8'h01);
    chk("trim_busy", 8'(busy), 8'h01);
    for (cnt = 0; cnt < 40 && nvm === 1'b1; cnt++) @(posedge clk_sys_i) #1;
    chk("trim_len", 8'(cnt), 8'(ACR_TRIM_CNT));
    repeat (2) @(posedge clk_sys_i);
    host.rd(ACR_ADDR_IF_RESET, d);
    chk("trim_clear", d, 8'h00);
    $display("test trim done");
    host.wr(ACR_ADDR_RATE_MODE, 8'h28);
    @(posedge clk_sys_i);
    conv <= 1'b1;
    @(posedge clk_sys_i);
    conv <= 1'b0;
    #1 chk("sample_hi", 8'(sample), 8'h01);
    @(posedge clk_sys_i) #1;
    chk("sample_lo", 8'(sample), 8'h00);
    $display("test single done");
    @(posedge clk_sys_i);
    ce <= 1'b0;
    host.wr(ACR_ADDR_RATE_MODE, 8'h10);
    ce <= 1'b1;
    host.rd(ACR_ADDR_RATE_MODE, d);
    chk("ce_freeze", d, 8'h28);
    $display("test clock enable done");
    wrap_up();
  end
endmodule
